// File: src/fp_access_pkg.sv
// shared constants and types of the front panel access controller
package fp_access_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd250_000_000;
  localparam longint unsigned HOLD_S = 64'd5;
  localparam longint unsigned SHOW_S = 64'd3;
  // "brief" refusal message length
  localparam longint unsigned BRIEF_MS = 64'd1000;
  localparam longint unsigned HOLD_CYC = HOLD_S * CLK_HZ;
  localparam longint unsigned SHOW_CYC = SHOW_S * CLK_HZ;
  localparam longint unsigned BRIEF_CYC = BRIEF_MS * CLK_HZ / 64'd1000;
  localparam int TMR_W = 32;

  // ---------------------------------------------------------------
  // outputs and values
  // ---------------------------------------------------------------
  localparam int NUM_OUT = 3;
  localparam logic [11:0] LOCK_CODE_RST = 12'h123;
  localparam logic [3:0] RANGE_OFF = 4'h0;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic signed [7:0] STILL_MIN = 8'sh9c;
  localparam logic signed [7:0] STILL_MAX = 8'sh64;
  localparam logic signed [7:0] STILL_RST = 8'sh00;

  // ---------------------------------------------------------------
  // keypad codes
  // ---------------------------------------------------------------
  localparam logic [3:0] KEY_DIGIT_MAX = 4'h9;
  localparam logic [3:0] KEY_ENTER = 4'ha;
  localparam logic [3:0] KEY_ALL_OFF = 4'hb;
  localparam logic [3:0] KEY_REMOTE = 4'hc;

  typedef enum logic [1:0] {IF_USB, IF_ETH, IF_GPIB} host_if_type;
  typedef enum logic [1:0] {MODE_OPEN, MODE_MONITOR, MODE_STILL}
    out_mode_type;
  typedef enum logic [1:0] {MSG_NONE, MSG_LOCKED, MSG_UNLOCKED} msg_type;
  typedef enum logic [3:0] {
    CMD_RANGE, CMD_PU_EN, CMD_MODE, CMD_MANUAL, CMD_STILL,
    CMD_IFACE, CMD_LOCK_CODE, CMD_DEFAULTS, CMD_REMOTE, CMD_LOCAL
  } cmd_type;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } key_type;

  typedef struct packed {
    logic valid;
    cmd_type cmd;
    logic [1:0] index;
    logic [11:0] data;
  } cmd_req_type;

  typedef struct packed {
    logic locked;
    logic [11:0] lock_code;
    host_if_type host_if;
    out_mode_type mode;
    logic signed [7:0] still_pct;
    logic [NUM_OUT-1:0] pu_en;
    logic [NUM_OUT-1:0][3:0] range;
  } cfg_type;

  localparam cfg_type CFG_RST = '{
    locked: 1'b0,
    lock_code: LOCK_CODE_RST,
    host_if: IF_USB,
    mode: MODE_OPEN,
    still_pct: STILL_RST,
    pu_en: 3'h0,
    range: {NUM_OUT{RANGE_OFF}}
  };

endpackage

// File: src/fp_sync.sv
// two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module fp_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  // meta is read by o_sync only
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// File: src/fp_timer.sv
// one-shot countdown timer with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fp_timer #(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [W-1:0] i_len,
  output logic o_busy,
  output logic o_done
);
  logic [W-1:0] count;

  // a restart reloads, so a stale countdown never fires
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_stop) begin
      count <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        count <= i_len;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        count <= count - 1'b1;
        if (count <= 1) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: src/fp_access_ctrl.sv
// front panel lock, remote/local and output configuration controller
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - hold Enter 5 s, key three digits, compare with stored code
// - stored three-digit lock code, factory value 123
// - match while unlocked locks, shows locked message 3 s, then normal
// - same sequence unlocks, shows unlocked message 3 s
// - locked: panel parameter change refused, locked message shown briefly
// - locked: only shutdown-all key still acts; the remote/local key also acts while in remote
// - lock code changed only from the host interface; a panel restore to defaults while unlocked also sets it back to 123
// - restoring defaults restores lock code too
// - panel restore to defaults refused while locked
// - one host interface active, USB by default
// - remote: only remote/local and shutdown-all keys act
// - remote indicator lit exactly in remote mode
// - configuration kept across power cycle
// - power-up enable off forces output off at power-up
// - power-up enable on restores previous output setting
// - output mode open loop, monitor or still; still shares manual value
// - still percentage accepted from -100 to +100
// - shutdown-all sets every output range off at once
module fp_access_ctrl
  import fp_access_pkg::*;
#(
  parameter logic [TMR_W-1:0] HOLD_LEN = TMR_W'(HOLD_CYC),
  parameter logic [TMR_W-1:0] SHOW_LEN = TMR_W'(SHOW_CYC),
  parameter logic [TMR_W-1:0] BRIEF_LEN = TMR_W'(BRIEF_CYC)
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_enter_pin,
  input wire key_type i_key,
  input wire cmd_req_type i_panel,
  input wire cmd_req_type i_host,
  input wire host_if_type i_host_src,
  input wire logic i_nv_valid,
  input wire cfg_type i_nv_cfg,
  output cfg_type o_cfg,
  output logic o_locked,
  output logic o_remote_led,
  output msg_type o_msg,
  output logic o_refused
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD, SEQ_DIGITS, SEQ_CHECK}
    seq_type;

  seq_type seq;
  logic loaded;
  logic enter_s;
  logic enter_d;
  logic hold_start;
  logic hold_busy;
  logic hold_done;
  logic msg_busy;
  logic msg_done;
  logic [11:0] digits;
  logic [1:0] dig_cnt;
  logic host_ok;
  logic panel_ok;
  logic refuse;
  logic is_digit;
  logic all_off;
  logic remote_key;
  logic code_match;
  logic show_long;
  logic msg_start;
  logic [TMR_W-1:0] msg_len;
  cfg_type next_cfg;
  logic [11:0] pu_mask;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  function automatic cfg_type apply_cmd(input cfg_type c,
                                        input cmd_req_type r,
                                        input logic from_host);
    cfg_type n;
    logic signed [7:0] pct;
    logic pct_ok;
    n = c;
    pct = r.data[7:0];
    pct_ok = (pct >= STILL_MIN) && (pct <= STILL_MAX);
    case (r.cmd)
      CMD_RANGE: begin
        if (r.index < NUM_OUT) begin
          n.range[r.index] = r.data[3:0];
        end
      end
      CMD_PU_EN: begin
        if (r.index < NUM_OUT) begin
          n.pu_en[r.index] = r.data[0];
        end
      end
      CMD_MODE: begin
        if (r.data[1:0] != 2'h3) begin
          n.mode = out_mode_type'(r.data[1:0]);
        end
      end
      CMD_MANUAL: begin
        if (c.mode == MODE_OPEN && pct_ok) begin
          n.still_pct = pct;
        end
      end
      CMD_STILL: begin
        if (c.mode == MODE_STILL && pct_ok) begin
          n.still_pct = pct;
        end
      end
      CMD_IFACE: begin
        if (r.data[1:0] != 2'h3) begin
          n.host_if = host_if_type'(r.data[1:0]);
        end
      end
      CMD_LOCK_CODE: begin
        // bcd digits only, and never from the keypad
        if (from_host && r.data[11:8] <= BCD_MAX &&
            r.data[7:4] <= BCD_MAX && r.data[3:0] <= BCD_MAX) begin
          n.lock_code = r.data;
        end
      end
      CMD_DEFAULTS: begin
        n = CFG_RST;
        n.locked = c.locked;
      end
      default: begin
        n = c;
      end
    endcase
    return n;
  endfunction

  // ---------------------------------------------------------------
  // inputs and qualifiers
  // ---------------------------------------------------------------
  fp_sync #(.W(1)) u_enter_sync (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_async(i_enter_pin),
    .o_sync(enter_s)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      enter_d <= 1'b0;
    end else begin
      enter_d <= enter_s;
    end
  end

  // commands from an inactive interface are dropped
  assign host_ok = i_host.valid && loaded &&
                   (i_host_src == o_cfg.host_if);
  assign is_digit = i_key.valid && (i_key.code <= KEY_DIGIT_MAX);
  assign all_off = i_key.valid && (i_key.code == KEY_ALL_OFF) &&
                   loaded;
  // toggle key: always in remote, blocked by the lock in local
  assign remote_key = i_key.valid && (i_key.code == KEY_REMOTE) &&
                      loaded && (o_remote_led || !o_cfg.locked);
  assign panel_ok = i_panel.valid && loaded && !o_remote_led &&
                    !o_cfg.locked;
  assign refuse = i_panel.valid && loaded && !o_remote_led &&
                  o_cfg.locked;
  assign code_match = (digits == o_cfg.lock_code);
  assign show_long = (seq == SEQ_CHECK) && code_match;
  assign msg_start = show_long || refuse;
  assign msg_len = show_long ? SHOW_LEN : BRIEF_LEN;
  assign hold_start = (seq == SEQ_IDLE) && enter_s && !enter_d &&
                      !o_remote_led && loaded;
  // nibble mask of the outputs whose stored setting survives power-up
  assign pu_mask = {{4{i_nv_cfg.pu_en[2]}}, {4{i_nv_cfg.pu_en[1]}},
                    {4{i_nv_cfg.pu_en[0]}}};

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  fp_timer #(.W(TMR_W)) u_hold_tmr (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_start(hold_start),
    .i_stop(!enter_s),
    .i_len(HOLD_LEN),
    .o_busy(hold_busy),
    .o_done(hold_done)
  );

  fp_timer #(.W(TMR_W)) u_msg_tmr (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_start(msg_start),
    .i_stop(1'b0),
    .i_len(msg_len),
    .o_busy(msg_busy),
    .o_done(msg_done)
  );

  // ---------------------------------------------------------------
  // lock sequence
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      seq <= SEQ_IDLE;
      dig_cnt <= 2'h0;
      digits <= 12'h000;
    end else begin
      case (seq)
        SEQ_IDLE: begin
          if (hold_start) begin
            seq <= SEQ_HOLD;
          end
        end
        SEQ_HOLD: begin
          // early release abandons the hold
          if (!enter_s || o_remote_led) begin
            seq <= SEQ_IDLE;
          end else if (hold_done) begin
            seq <= SEQ_DIGITS;
            dig_cnt <= 2'h0;
          end
        end
        SEQ_DIGITS: begin
          if (o_remote_led) begin
            seq <= SEQ_IDLE;
          end else if (is_digit) begin
            digits <= {digits[7:0], i_key.code};
            if (dig_cnt == 2'h2) begin
              seq <= SEQ_CHECK;
            end else begin
              dig_cnt <= dig_cnt + 2'h1;
            end
          end else if (i_key.valid && i_key.code != KEY_ALL_OFF &&
                       i_key.code != KEY_ENTER) begin
            seq <= SEQ_IDLE;
          end
        end
        SEQ_CHECK: begin
          seq <= SEQ_IDLE;
        end
        default: begin
          seq <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // display message and refusal strobe
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_msg <= MSG_NONE;
    end else if (show_long) begin
      o_msg <= o_cfg.locked ? MSG_UNLOCKED : MSG_LOCKED;
    end else if (refuse) begin
      o_msg <= MSG_LOCKED;
    end else if (seq == SEQ_CHECK) begin
      o_msg <= MSG_NONE;
    end else if (msg_done) begin
      o_msg <= MSG_NONE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_refused <= 1'b0;
    end else begin
      o_refused <= refuse;
    end
  end

  // ---------------------------------------------------------------
  // remote / local
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_remote_led <= 1'b0;
    end else if (host_ok && i_host.cmd == CMD_REMOTE) begin
      o_remote_led <= 1'b1;
    end else if (host_ok && i_host.cmd == CMD_LOCAL) begin
      o_remote_led <= 1'b0;
    end else if (remote_key) begin
      o_remote_led <= !o_remote_led;
    end
  end

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  always_comb begin
    next_cfg = o_cfg;
    if (!loaded) begin
      // first cycle after reset: pick up the stored image
      if (i_nv_valid) begin
        next_cfg = i_nv_cfg;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        if (!next_cfg.pu_en[i]) begin
          next_cfg.range[i] = RANGE_OFF;
        end
      end
    end else begin
      if (host_ok) begin
        next_cfg = apply_cmd(next_cfg, i_host, 1'b1);
      end
      if (panel_ok) begin
        next_cfg = apply_cmd(next_cfg, i_panel, 1'b0);
      end
      if (show_long) begin
        next_cfg.locked = !o_cfg.locked;
      end
      // applied last so no same-cycle write can undo it
      if (all_off) begin
        next_cfg.range = {NUM_OUT{RANGE_OFF}};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_cfg <= CFG_RST;
    end else begin
      o_cfg <= next_cfg;
    end
  end

  assign o_locked = o_cfg.locked;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  AST_DIGITS: assert property (
    seq == SEQ_DIGITS && dig_cnt == 2'h2 && is_digit && !o_remote_led
    |=> seq == SEQ_CHECK && digits[3:0] == $past(i_key.code)
  ) else $error("third digit did not start the code check");

  AST_DEFAULT_CODE: assert property (
    $rose(loaded) && !$past(i_nv_valid) |-> o_cfg.lock_code == 12'h123
  ) else $error("lock code not at factory value after reset");

  AST_LOCK: assert property (
    show_long && !o_cfg.locked
    |=> o_locked && o_msg == MSG_LOCKED
  ) else $error("matching code did not lock");

  AST_MSG_END: assert property (
    msg_done && !msg_start && seq != SEQ_CHECK |=> o_msg == MSG_NONE
  ) else $error("message not cleared when its time ran out");

  AST_UNLOCK: assert property (
    show_long && o_cfg.locked
    |=> !o_locked && o_msg == MSG_UNLOCKED ##1 o_msg == MSG_UNLOCKED
  ) else $error("matching code did not unlock");

  AST_REFUSE: assert property (
    refuse && !show_long |=> o_refused && o_msg == MSG_LOCKED
  ) else $error("locked panel change not refused");

  AST_LOCKED_PANEL: assert property (
    o_cfg.locked && !host_ok && !show_long && loaded
    |=> $stable(o_cfg.still_pct) && $stable(o_cfg.mode) &&
        $stable(o_cfg.pu_en)
  ) else $error("panel changed a setting while locked");

  AST_CODE_HOST: assert property (
    loaded && !host_ok &&
    !(panel_ok && i_panel.cmd == CMD_DEFAULTS)
    |=> $stable(o_cfg.lock_code)
  ) else $error("lock code changed without a host command");

  AST_DEFAULTS: assert property (
    host_ok && i_host.cmd == CMD_DEFAULTS &&
    !(panel_ok && i_panel.cmd == CMD_IFACE)
    |=> o_cfg.lock_code == LOCK_CODE_RST && o_cfg.host_if == IF_USB
  ) else $error("defaults did not restore the lock code");

  AST_NO_RESET_LOCKED: assert property (
    refuse && i_panel.cmd == CMD_DEFAULTS && !host_ok && !all_off &&
    !show_long
    |=> $stable(o_cfg) && o_refused
  ) else $error("panel reset acted while locked");

  AST_IF_LEGAL: assert property (
    o_cfg.host_if inside {IF_USB, IF_ETH, IF_GPIB}
  ) else $error("no legal host interface selected");

  AST_REMOTE_IGNORE: assert property (
    o_remote_led && loaded && !host_ok && !all_off
    |=> $stable(o_cfg) && !o_refused
  ) else $error("panel acted in remote mode");

  AST_LED: assert property (
    o_remote_led && remote_key && !host_ok |=> !o_remote_led
  ) else $error("remote indicator did not follow local mode");

  AST_PU_OFF: assert property (
    !loaded && i_nv_valid
    |=> (o_cfg.range & ~$past(pu_mask)) == 12'h000
  ) else $error("output not forced off at power-up");

  AST_PU_ON: assert property (
    !loaded && i_nv_valid
    |=> (o_cfg.range & $past(pu_mask)) ==
        ($past(i_nv_cfg.range) & $past(pu_mask)) &&
        o_cfg.lock_code == $past(i_nv_cfg.lock_code)
  ) else $error("output setting not restored at power-up");

  AST_STILL_SPAN: assert property (
    loaded |-> o_cfg.still_pct >= STILL_MIN && o_cfg.still_pct <= STILL_MAX
  ) else $error("still percentage outside full scale");

  AST_ALL_OFF: assert property (
    all_off |=> o_cfg.range == {NUM_OUT{RANGE_OFF}}
  ) else $error("shutdown did not turn every output off");

  AST_MISMATCH: assert property (
    seq == SEQ_CHECK && !code_match
    |=> $stable(o_locked) && o_msg == MSG_NONE && seq == SEQ_IDLE
  ) else $error("code mismatch changed the lock state");

  COV_LOCK: cover property (show_long && !o_cfg.locked);
  COV_UNLOCK: cover property (show_long && o_cfg.locked);
  COV_REFUSE: cover property (refuse);
  COV_OFF_REMOTE: cover property (all_off && o_remote_led);

endmodule
`default_nettype wire

// File: verif/fp_operator_model.sv
// operator at the keypad and host computer driving the access controller
`timescale 1ns/1ps
`default_nettype none
module fp_operator_model
  import fp_access_pkg::*;
#(
  parameter int HOLD_WAIT = 26
) (
  input wire logic i_clk_sys,
  output var logic o_enter_pin,
  output var key_type o_key,
  output var cmd_req_type o_panel,
  output var cmd_req_type o_host,
  output var host_if_type o_host_src
);
  initial begin
    o_enter_pin = 1'b0;
    o_key = '0;
    o_panel = '0;
    o_host = '0;
    o_host_src = IF_USB;
  end

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      #1;
    end
  endtask

  // ---------------------------------------------------------------
  // keypad
  // ---------------------------------------------------------------
  // gap of at least one cycle so a pulse never restarts in its own step
  task automatic press(input logic [3:0] c, input int gap);
    o_key = '{valid: 1'b1, code: c};
    idle(1);
    o_key = '0;
    idle(gap);
  endtask

  // long Enter hold, then three digits, first digit most significant
  task automatic key_code(input logic [11:0] d, input int gap);
    o_enter_pin = 1'b1;
    idle(HOLD_WAIT);
    for (int k = 2; k >= 0; k--) begin
      press(d[k*4+:4], gap);
    end
    o_enter_pin = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // panel and host requests
  // ---------------------------------------------------------------
  task automatic send(input logic h, input host_if_type s,
                      input cmd_type c, input logic [1:0] i,
                      input logic [11:0] d);
    o_host_src = s;
    if (h) begin
      o_host = '{1'b1, c, i, d};
    end else begin
      o_panel = '{1'b1, c, i, d};
    end
    idle(1);
    o_host = '0;
    o_panel = '0;
    idle(1);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_front_panel_lock_remote_ctrl.sv
// self-checking bench of the front panel access controller
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_lock_remote_ctrl
  import fp_access_pkg::*;
;
  localparam int HL = 20;
  localparam int SL = 12;
  localparam int BL = 6;
  typedef struct packed {
    logic h;
    host_if_type src;
    cmd_type cmd;
    logic [1:0] idx;
    logic [11:0] d;
    logic [2:0] sel;
    logic [11:0] exp;
  } row_type;
  logic clk = 1'b0;
  logic srst;
  logic nv_valid;
  cfg_type nv_cfg;
  cfg_type cfg;
  cfg_type img;
  cfg_type exp;
  logic locked;
  logic led;
  logic refused;
  msg_type msg;
  logic enter;
  key_type key;
  cmd_req_type panel;
  cmd_req_type host;
  host_if_type src;
  int n_fail = 0;
  int cmp_count = 0;
  int n_ref = 0;
  int n;
  int n0;
  // sel: 0 code, 1 interface, 2 mode, 3 still, 4 power-up, 5 ranges
  row_type rows [19] = '{
    '{1'b1, IF_USB, CMD_RANGE, 2'h0, 12'h005, 3'h5, 12'h005},
    '{1'b0, IF_USB, CMD_RANGE, 2'h2, 12'h003, 3'h5, 12'h305},
    '{1'b1, IF_USB, CMD_PU_EN, 2'h1, 12'h001, 3'h4, 12'h002},
    '{1'b0, IF_USB, CMD_MODE, 2'h0, 12'h003, 3'h2, 12'h000},
    '{1'b1, IF_USB, CMD_STILL, 2'h0, 12'h010, 3'h3, 12'h000},
    '{1'b1, IF_USB, CMD_MANUAL, 2'h0, 12'h09c, 3'h3, 12'h09c},
    '{1'b0, IF_USB, CMD_MODE, 2'h0, 12'h002, 3'h2, 12'h002},
    '{1'b0, IF_USB, CMD_STILL, 2'h0, 12'h064, 3'h3, 12'h064},
    '{1'b1, IF_USB, CMD_STILL, 2'h0, 12'h065, 3'h3, 12'h064},
    '{1'b1, IF_USB, CMD_MANUAL, 2'h0, 12'h000, 3'h3, 12'h064},
    '{1'b0, IF_USB, CMD_LOCK_CODE, 2'h0, 12'h456, 3'h0, 12'h123},
    '{1'b1, IF_USB, CMD_LOCK_CODE, 2'h0, 12'h4a5, 3'h0, 12'h123},
    '{1'b1, IF_USB, CMD_LOCK_CODE, 2'h0, 12'h456, 3'h0, 12'h456},
    '{1'b0, IF_USB, CMD_MODE, 2'h0, 12'h001, 3'h2, 12'h001},
    '{1'b0, IF_USB, CMD_IFACE, 2'h0, 12'h001, 3'h1, 12'h001},
    '{1'b1, IF_USB, CMD_RANGE, 2'h1, 12'h007, 3'h5, 12'h305},
    '{1'b1, IF_ETH, CMD_IFACE, 2'h0, 12'h002, 3'h1, 12'h002},
    '{1'b1, IF_GPIB, CMD_IFACE, 2'h0, 12'h000, 3'h1, 12'h000},
    '{1'b1, IF_USB, CMD_RANGE, 2'h1, 12'h007, 3'h5, 12'h375}
  };

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (refused === 1'b1) begin
      n_ref <= n_ref + 1;
    end
  end

  fp_operator_model #(.HOLD_WAIT(HL + 6)) op_u (
    .i_clk_sys(clk), .o_enter_pin(enter), .o_key(key), .o_panel(panel),
    .o_host(host), .o_host_src(src)
  );

  fp_access_ctrl #(
    .HOLD_LEN(32'(HL)), .SHOW_LEN(32'(SL)), .BRIEF_LEN(32'(BL))
  ) dut_u (
    .i_clk_sys(clk), .i_srst(srst), .i_enter_pin(enter), .i_key(key),
    .i_panel(panel), .i_host(host), .i_host_src(src),
    .i_nv_valid(nv_valid), .i_nv_cfg(nv_cfg), .o_cfg(cfg),
    .o_locked(locked), .o_remote_led(led), .o_msg(msg),
    .o_refused(refused)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] fld(input cfg_type c, input logic [2:0] s);
    case (s)
      3'h0: return c.lock_code;
      3'h1: return {10'h0, c.host_if};
      3'h2: return {10'h0, c.mode};
      3'h3: return {4'h0, c.still_pct};
      3'h4: return {9'h0, c.pu_en};
      default: return c.range;
    endcase
  endfunction

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] seen,
                     input logic [39:0] xp);
    cmp_count++;
    if (seen !== xp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, xp, seen);
    end
  endtask

  // bounded wait; a message that never shows ends the run
  task automatic wait_msg(input msg_type m, input int lim, output int k);
    k = 0;
    while (msg !== m && k < lim) begin
      op_u.idle(1);
      k++;
    end
    if (msg !== m) begin
      n_fail++;
      $display("Error o_msg expected %h seen %h", m, msg);
      report_and_stop();
    end
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    nv_valid = 1'b0;
    nv_cfg = CFG_RST;
    op_u.idle(16);
    srst = 1'b0;
    op_u.idle(1);
    chk("cfg after reset", cfg, CFG_RST);
    chk("led after reset", led, 1'b0);
    op_u.idle(2);
    foreach (rows[k]) begin
      op_u.send(rows[k].h, rows[k].src, rows[k].cmd, rows[k].idx, rows[k].d);
      chk("row field", fld(cfg, rows[k].sel), rows[k].exp);
    end
    op_u.key_code(12'h456, 1);
    wait_msg(MSG_LOCKED, 10, n);
    chk("locked", locked, 1'b1);
    wait_msg(MSG_NONE, 40, n);
    chk("show time", n >= SL - 1 && n <= SL + 1, 1'b1);
    n0 = n_ref;
    op_u.send(1'b0, IF_USB, CMD_RANGE, 2'h0, 12'h009);
    chk("refusal pulse", 40'(n_ref - n0), 40'h1);
    chk("refusal msg", msg, MSG_LOCKED);
    chk("range kept", cfg.range, 12'h375);
    wait_msg(MSG_NONE, 20, n);
    chk("brief time", n >= BL - 2 && n <= BL + 1, 1'b1);
    n0 = n_ref;
    op_u.send(1'b0, IF_USB, CMD_DEFAULTS, 2'h0, 12'h000);
    chk("defaults refused", 40'(n_ref - n0), 40'h1);
    chk("code kept", cfg.lock_code, 12'h456);
    op_u.press(KEY_ALL_OFF, 1);
    chk("locked all off", cfg.range, 12'h000);
    op_u.press(KEY_REMOTE, 1);
    chk("locked remote key", led, 1'b0);
    wait_msg(MSG_NONE, 20, n);
    op_u.key_code(12'h123, 2);
    op_u.idle(4);
    chk("wrong code lock", locked, 1'b1);
    chk("wrong code msg", msg, MSG_NONE);
    op_u.key_code(12'h456, 1);
    wait_msg(MSG_UNLOCKED, 10, n);
    chk("unlocked", locked, 1'b0);
    op_u.send(1'b1, IF_USB, CMD_DEFAULTS, 2'h0, 12'h000);
    chk("code restored", cfg.lock_code, LOCK_CODE_RST);
    op_u.send(1'b1, IF_USB, CMD_REMOTE, 2'h0, 12'h000);
    chk("led remote", led, 1'b1);
    op_u.send(1'b1, IF_USB, CMD_RANGE, 2'h0, 12'h002);
    n0 = n_ref;
    op_u.send(1'b0, IF_USB, CMD_RANGE, 2'h1, 12'h004);
    chk("remote no pulse", 40'(n_ref - n0), 40'h0);
    chk("remote range", cfg.range, 12'h002);
    op_u.press(KEY_ALL_OFF, 1);
    chk("remote all off", cfg.range, 12'h000);
    op_u.press(KEY_REMOTE, 1);
    chk("led local", led, 1'b0);
    op_u.send(1'b1, IF_USB, CMD_REMOTE, 2'h0, 12'h000);
    op_u.send(1'b1, IF_USB, CMD_LOCAL, 2'h0, 12'h000);
    chk("led host local", led, 1'b0);
    // power cycle: output 1 has power-up enable off, so it comes up off
    img = '{locked: 1'b0, lock_code: 12'h789, host_if: IF_ETH,
            mode: MODE_STILL, still_pct: 8'sh20, pu_en: 3'h5,
            range: 12'h321};
    exp = img;
    exp.range[1] = RANGE_OFF;
    srst = 1'b1;
    nv_cfg = img;
    nv_valid = 1'b1;
    op_u.idle(16);
    srst = 1'b0;
    op_u.idle(3);
    chk("stored image", cfg, exp);
    report_and_stop();
  end
endmodule
`default_nettype wire
